// >>> rtl/pms_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
module pms_pin_mux (
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    input  wire pms_pkg::pms_mode_t         mode_sel,
    input  wire pms_pkg::pms_rx_t           core_rx,
    output pms_pkg::pms_tx_t                core_tx,
    output logic                            core_tx_valid,
    input  wire logic [pms_pkg::IRQ_W-1:0]  irq_event,
    input  wire logic [pms_pkg::IRQ_W-1:0]  irq_enable,
    input  wire logic [pms_pkg::IRQ_W-1:0]  irq_clear,
    input  wire logic                       irq_active_high,
    output logic [pms_pkg::IRQ_W-1:0]       irq_pending,
    output logic                            interrupt_pin,
    output pms_pkg::pms_strap_t             strap,
    output logic                            strap_done,
    input  wire logic [3:0]                 rxd_i,
    output logic [3:0]                      rxd_o,
    output logic [3:0]                      rxd_oe,
    input  wire logic                       rx_dv_i,
    output logic                            rx_dv_o,
    output logic                            rx_dv_oe,
    input  wire logic                       rx_er_i,
    output logic                            rx_er_o,
    output logic                            rx_er_oe,
    input  wire logic                       col_i,
    output logic                            col_o,
    output logic                            col_oe,
    input  wire logic                       crs_i,
    output logic                            crs_o,
    output logic                            crs_oe,
    output logic                            rx_clk,
    input  wire logic                       tx_clk_i,
    output logic                            tx_clk_o,
    output logic                            tx_clk_oe,
    input  wire logic [3:0]                 txd_i,
    input  wire logic                       tx_en_i
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    // one smii receive segment, first bit in bit 0
    function automatic logic [9:0] smii_seg(input pms_pkg::pms_rx_t r);
        smii_seg = {r.data, r.dv, r.crs};
    endfunction : smii_seg

    // mask of the receive data pins a mode uses
    function automatic logic [3:0] rxd_used(input pms_pkg::pms_mode_t m);
        case (m)
            pms_pkg::PMS_RMII: rxd_used = 4'h3;
            pms_pkg::PMS_SMII: rxd_used = 4'h1;
            default:           rxd_used = 4'hf;
        endcase
    endfunction : rxd_used

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [pms_pkg::P_W-1:0] pin_raw;   // pins as they arrive
    logic [pms_pkg::P_W-1:0] pin_s1;    // first stage, read by s2 only
    logic [pms_pkg::P_W-1:0] pin_s;     // safe to use

    assign pin_raw = {tx_clk_i, tx_en_i, txd_i, crs_i, col_i,
                      rx_er_i, rx_dv_i, rxd_i};

    // two flops on every pin, straps and link clocks alike
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= '0;
            pin_s  <= '0;
        end else begin
            pin_s1 <= pin_raw;
            pin_s  <= pin_s1;
        end
    end

    // ----------------------------------------------------------------
    // strap window
    // ----------------------------------------------------------------
    logic [2:0] strap_cnt;      // cycles since reset release
    logic       strapping;      // pins undriven, straps being read

    assign strapping  = (strap_cnt != pms_pkg::STRAP_CYC);
    assign strap_done = ~strapping;

    // window spans the synchroniser delay so settled levels are seen
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt <= '0;
        end else if (strapping) begin
            strap_cnt <= strap_cnt + 3'h1;
        end
    end

    // sampled only inside the window, frozen after it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap <= '0;
        end else if (strapping) begin
            strap.duplex      <= pin_s[pms_pkg::P_RXD];
            strap.mode[2]     <= pin_s[pms_pkg::P_RXDV];
            strap.isolate     <= pin_s[pms_pkg::P_RXER];
            strap.mode[0]     <= pin_s[pms_pkg::P_COL];
            strap.mode[1]     <= pin_s[pms_pkg::P_CRS];
            strap.phy_addr[0] <= pin_s[pms_pkg::P_RXD+3];
            strap.phy_addr[1] <= pin_s[pms_pkg::P_RXD+2];
            strap.phy_addr[2] <= pin_s[pms_pkg::P_RXD+1];
        end
    end

    // ----------------------------------------------------------------
    // clocks: own divider and external edge finders
    // ----------------------------------------------------------------
    logic [1:0] div_cnt;        // quarter-rate clock phase
    logic       own_rise;       // own clock rising this cycle
    logic       txc_d;          // last synced transmit clock
    logic       ext_rise;       // partner clock rose
    logic       sync_d;         // last synced smii sync
    logic       sync_rise;      // new smii segment begins
    logic       tick;           // transmit sample point

    assign own_rise  = (div_cnt == pms_pkg::DIV_RISE);
    assign ext_rise  = pin_s[pms_pkg::P_TXC] & ~txc_d;
    assign sync_rise = pin_s[pms_pkg::P_TXD+1] & ~sync_d;
    assign tick      = (mode_sel == pms_pkg::PMS_B2B) ? ext_rise
                                                      : own_rise;

    // divider and edge history
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt  <= '0;
            txc_d    <= 1'b0;
            sync_d   <= 1'b0;
            tx_clk_o <= 1'b0;
            rx_clk   <= 1'b0;
        end else begin
            div_cnt  <= div_cnt + 2'h1;
            txc_d    <= pin_s[pms_pkg::P_TXC];
            sync_d   <= pin_s[pms_pkg::P_TXD+1];
            tx_clk_o <= own_rise;
            rx_clk   <= own_rise;
        end
    end

    // transmit clock pin driven only in mii mode, so it is an input in back-to-back, rmii and smii
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_clk_oe <= 1'b0;
        end else begin
            tx_clk_oe <= (mode_sel == pms_pkg::PMS_MII) &&
                         !strap.isolate && !strapping;
        end
    end

    // ----------------------------------------------------------------
    // smii serialiser and deserialiser
    // ----------------------------------------------------------------
    logic [3:0] smii_bit;       // bit position in segment
    logic [9:0] smii_rx_sr;     // outgoing receive segment
    logic [9:0] smii_tx_sr;     // incoming transmit segment
    logic       smii_tx_end;    // last incoming bit this cycle

    assign smii_tx_end = (mode_sel == pms_pkg::PMS_SMII) &&
                         (smii_bit == pms_pkg::SMII_LAST);

    // sync restarts the segment; a missed sync just idles at the end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            smii_bit   <= pms_pkg::SMII_LAST;
            smii_rx_sr <= '0;
            smii_tx_sr <= '0;
        end else if (sync_rise) begin
            smii_bit   <= '0;
            smii_rx_sr <= smii_seg(core_rx);
            smii_tx_sr <= {pin_s[pms_pkg::P_TXD], smii_tx_sr[9:1]};
        end else begin
            if (smii_bit != pms_pkg::SMII_LAST) begin
                smii_bit <= smii_bit + 4'h1;
            end
            smii_rx_sr <= {1'b0, smii_rx_sr[9:1]};
            smii_tx_sr <= {pin_s[pms_pkg::P_TXD], smii_tx_sr[9:1]};
        end
    end

    // ----------------------------------------------------------------
    // transmit words toward the core
    // ----------------------------------------------------------------
    // one word per sample point, or per smii cycle at SMII_LAST with no sync rising
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_tx       <= '0;
            core_tx_valid <= 1'b0;
        end else begin
            core_tx_valid <= 1'b0;
            if (strapping) begin
                core_tx_valid <= 1'b0;      // pins not yet trusted
            end else if (mode_sel == pms_pkg::PMS_SMII) begin
                if (smii_tx_end && !sync_rise) begin
                    core_tx.er    <= smii_tx_sr[1];
                    core_tx.en    <= smii_tx_sr[2];
                    core_tx.data  <= {pin_s[pms_pkg::P_TXD],
                                      smii_tx_sr[9:3]};
                    core_tx_valid <= 1'b1;
                end
            end else if (tick) begin
                core_tx.er    <= 1'b0;
                core_tx.en    <= pin_s[pms_pkg::P_TXEN];
                core_tx.data  <= (mode_sel == pms_pkg::PMS_RMII)
                    ? {6'h00, pin_s[pms_pkg::P_TXD +: 2]}
                    : {4'h0, pin_s[pms_pkg::P_TXD +: 4]};
                core_tx_valid <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // receive pin drivers
    // ----------------------------------------------------------------
    logic drive;                // mac pins owned by this block

    assign drive = !strapping && !strap.isolate;

    // output values per mode, registered
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxd_o   <= '0;
            rx_dv_o <= 1'b0;
            rx_er_o <= 1'b0;
            col_o   <= 1'b0;
            crs_o   <= 1'b0;
        end else begin
            rx_er_o <= core_rx.er;
            col_o   <= core_rx.col;
            crs_o   <= core_rx.crs;
            case (mode_sel)
                pms_pkg::PMS_RMII: begin
                    rxd_o   <= {2'h0, core_rx.data[1:0]};
                    rx_dv_o <= core_rx.crs | core_rx.dv;
                end
                pms_pkg::PMS_SMII: begin
                    rxd_o   <= {3'h0, smii_rx_sr[0]};
                    rx_dv_o <= 1'b0;
                end
                default: begin
                    rxd_o   <= core_rx.data[3:0];
                    rx_dv_o <= core_rx.dv;
                end
            endcase
        end
    end

    // enables: nothing driven during the strap window
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxd_oe   <= '0;
            rx_dv_oe <= 1'b0;
            rx_er_oe <= 1'b0;
            col_oe   <= 1'b0;
            crs_oe   <= 1'b0;
        end else begin
            rxd_oe   <= drive ? rxd_used(mode_sel) : 4'h0;
            rx_dv_oe <= drive && (mode_sel != pms_pkg::PMS_SMII);
            rx_er_oe <= drive && (mode_sel != pms_pkg::PMS_SMII);
            col_oe   <= drive && (rxd_used(mode_sel) == 4'hf);
            crs_oe   <= drive && (rxd_used(mode_sel) == 4'hf);
        end
    end

    // ----------------------------------------------------------------
    // interrupt status and pin
    // ----------------------------------------------------------------
    // sticky; an event in the clearing cycle survives the clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_pending <= pms_pkg::IRQ_RST;
        end else begin
            irq_pending <= (irq_pending & ~irq_clear) | irq_event;
        end
    end

    // polarity applied last; the registered level follows the bit one cycle later
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_pin <= ~pms_pkg::IRQ_POL_RST;
        end else begin
            interrupt_pin <= (|(irq_pending & irq_enable))
                             ~^ irq_active_high;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_sync_start;
        sync_rise && (mode_sel == pms_pkg::PMS_SMII) && drive;
    endsequence
    sequence s_first_bit;
        rxd_o[0] == $past(core_rx.crs, 2);
    endsequence

    a_strap_frozen: assert property (
        strap_done |=> $stable(strap))
        else $error("strap changed after window");
    a_strap_duplex: assert property (
        strapping ##1 strap_done |-> strap.duplex == $past(pin_s[0]))
        else $error("duplex strap not latched");
    a_strap_quiet: assert property (
        strapping |=> (rxd_oe == 4'h0) && !rx_dv_oe && !crs_oe)
        else $error("pin driven during strap window");
    a_isolate_pins: assert property (
        strap_done && strap.isolate |=> rxd_oe == 4'h0 && !col_oe)
        else $error("isolated device drives mac pins");
    a_irq_set_wins: assert property (
        irq_event[0] && irq_clear[0] |=> irq_pending[0])
        else $error("event lost under clear");
    a_irq_clears: assert property (
        irq_clear[0] && !irq_event[0] |=> !irq_pending[0])
        else $error("pending bit not cleared");
    a_irq_polarity: assert property (
        $stable(irq_active_high) && !(|(irq_pending & irq_enable))
        |=> interrupt_pin == !$past(irq_active_high))
        else $error("idle interrupt level wrong");
    a_txc_turn: assert property (
        mode_sel == pms_pkg::PMS_B2B |=> !tx_clk_oe)
        else $error("transmit clock driven in back-to-back");
    a_crs_dv_merge: assert property (
        mode_sel == pms_pkg::PMS_RMII && core_rx.crs
        |=> rx_dv_o)
        else $error("carrier sense missing from merged valid");
    a_smii_first: assert property (
        s_sync_start ##1 (mode_sel == pms_pkg::PMS_SMII) |=> s_first_bit)
        else $error("smii segment does not open with carrier");

endmodule : pms_pin_mux
`default_nettype wire

// >>> rtl/pms_pkg.sv
package pms_pkg;

    // ----------------------------------------------------------------
    // constants
    // ----------------------------------------------------------------
    localparam int unsigned  IRQ_W       = 8;      // interrupt sources
    localparam logic [2:0]   STRAP_CYC   = 3'h4;   // strap window length
    localparam logic [1:0]   DIV_RISE    = 2'h1;   // own clock high phase
    localparam logic [3:0]   SMII_LAST   = 4'h9;   // last bit of segment
    localparam logic         IRQ_POL_RST = 1'b0;   // active low default
    localparam logic [IRQ_W-1:0] IRQ_RST = 8'h00;  // pending after reset
    // synchronised pin vector positions
    localparam int unsigned  P_RXD    = 0;         // four bits
    localparam int unsigned  P_RXDV   = 4;
    localparam int unsigned  P_RXER   = 5;
    localparam int unsigned  P_COL    = 6;
    localparam int unsigned  P_CRS    = 7;
    localparam int unsigned  P_TXD    = 8;         // four bits
    localparam int unsigned  P_TXEN   = 12;
    localparam int unsigned  P_TXC    = 13;
    localparam int unsigned  P_W      = 14;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PMS_MII, PMS_RMII, PMS_SMII, PMS_B2B
    } pms_mode_t;

    typedef struct packed {
        logic [7:0] data;   // nibble/dibit in low bits
        logic       dv;
        logic       er;
        logic       crs;
        logic       col;
    } pms_rx_t;

    typedef struct packed {
        logic [7:0] data;
        logic       en;
        logic       er;
    } pms_tx_t;

    typedef struct packed {
        logic       duplex;
        logic       isolate;
        logic [2:0] mode;       // mode_strap_bit2..0
        logic [2:0] phy_addr;   // phy_addr_strap_bit0 in bit 0
    } pms_strap_t;

endpackage : pms_pkg

// >>> sim/pms_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// mac side model: transmit pins, sync and back-to-back clock
// ------------------------------------------------------------------
module pms_mac_model (
    input  wire logic               sys_clk,
    input  wire pms_pkg::pms_mode_t mode,
    input  wire logic               go,
    input  wire logic [3:0]         word,
    output logic [3:0]              txd,
    output logic                    tx_en,
    output logic                    tx_clk
);
    logic [3:0] sync_cnt = 4'h0;    // position in smii segment
    logic       clk_q    = 1'b0;    // one process owns the link clock

    // link clock runs only inside back-to-back frames, 80 ns period
    always #40 clk_q = (go && mode == pms_pkg::PMS_B2B) ? ~clk_q : 1'b0;
    assign tx_clk = clk_q;

    // ten bit segment counter for sync
    always @(posedge sys_clk) begin
        sync_cnt <= (sync_cnt == 4'h9) ? 4'h0 : sync_cnt + 4'h1;
    end

    // released lines show the inverse so stale data cannot match
    always_comb begin
        if (!go) begin
            txd   = ~word;
            tx_en = 1'b0;
        end else if (mode == pms_pkg::PMS_SMII) begin
            txd   = {2'h0, sync_cnt == 4'h0, 1'b0};
            tx_en = 1'b0;
        end else begin
            txd   = word;
            tx_en = 1'b1;
        end
    end
endmodule : pms_mac_model
`default_nettype wire

// >>> sim/pms_pin_mux_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pms_pin_mux_tb;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic               sys_clk = 1'b0;
    logic               rst_n = 1'b0;
    pms_pkg::pms_mode_t mode_sel = pms_pkg::PMS_MII;
    pms_pkg::pms_rx_t   core_rx = '0;
    pms_pkg::pms_tx_t   core_tx;
    logic               core_tx_valid;
    logic [7:0]         irq_event = 8'h00;
    logic [7:0]         irq_enable = 8'h00;
    logic [7:0]         irq_clear = 8'h00;
    logic               irq_active_high = 1'b0;
    logic [7:0]         irq_pending;
    logic               interrupt_pin;
    pms_pkg::pms_strap_t strap;
    logic               strap_done;
    logic [3:0]         rxd_o, rxd_oe;
    logic               dv_o, dv_oe, er_o, er_oe, col_o, col_oe;
    logic               crs_o, crs_oe, rx_clk, txc_o, txc_oe;
    logic [7:0]         pull = 8'h00;   // strap resistors {crs,col,er,dv,rxd}
    logic               mac_go = 1'b0;
    logic [3:0]         mac_word = 4'h0;
    logic [3:0]         mac_txd;
    logic               mac_tx_en, mac_tx_clk;
    logic [15:0]        tx_q[$];        // expected transmit words
    int                 err_total = 0;
    int                 n_compared = 0;
    integer             seed = 97;
    logic [31:0]        r;
    logic [29:0]        sh;
    logic [9:0]         pat;
    logic               found;
    int                 cnt;            // driven clock highs seen

    always #5 sys_clk = ~sys_clk;

    // pin level: driver if enabled, else the strap resistor
    pms_pin_mux DUT (.sys_clk(sys_clk), .rst_n(rst_n), .mode_sel(mode_sel),
        .core_rx(core_rx), .core_tx(core_tx), .core_tx_valid(core_tx_valid),
        .irq_event(irq_event), .irq_enable(irq_enable),
        .irq_clear(irq_clear), .irq_active_high(irq_active_high),
        .irq_pending(irq_pending), .interrupt_pin(interrupt_pin),
        .strap(strap), .strap_done(strap_done),
        .rxd_i((rxd_oe & rxd_o) | (~rxd_oe & pull[3:0])),
        .rxd_o(rxd_o), .rxd_oe(rxd_oe),
        .rx_dv_i(dv_oe ? dv_o : pull[4]), .rx_dv_o(dv_o), .rx_dv_oe(dv_oe),
        .rx_er_i(er_oe ? er_o : pull[5]), .rx_er_o(er_o), .rx_er_oe(er_oe),
        .col_i(col_oe ? col_o : pull[6]), .col_o(col_o), .col_oe(col_oe),
        .crs_i(crs_oe ? crs_o : pull[7]), .crs_o(crs_o), .crs_oe(crs_oe),
        .rx_clk(rx_clk), .tx_clk_i(txc_oe ? txc_o : mac_tx_clk),
        .tx_clk_o(txc_o), .tx_clk_oe(txc_oe),
        .txd_i(mac_txd), .tx_en_i(mac_tx_en));

    pms_mac_model MAC (.sys_clk(sys_clk), .mode(mode_sel), .go(mac_go),
        .word(mac_word), .txd(mac_txd), .tx_en(mac_tx_en),
        .tx_clk(mac_tx_clk));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_compared++;
        if (seen !== want) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    // resistors held through reset and the whole strap window
    task automatic do_reset(input pms_pkg::pms_mode_t m, input logic [7:0] p);
        @(negedge sys_clk);
        rst_n = 1'b0;
        mode_sel = m;
        pull = p;
        mac_go = 1'b0;
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge sys_clk);
    endtask : do_reset

    // strap word {duplex,isolate,mode[2:0],phy_addr[2:0]}
    function automatic logic [7:0] exp_strap(input logic [7:0] p);
        return {p[0], p[5], p[4], p[7], p[6], p[1], p[2], p[3]};
    endfunction : exp_strap

    // bounded wait until every queued transmit word was seen
    task automatic drain(input int lim);
        for (int k = 0; k < lim && tx_q.size() > 0; k++) @(negedge sys_clk);
        if (tx_q.size() > 0) begin
            err_total++;
            wrap_up();
        end
    endtask : drain

    // watcher: each new transmit word retires the oldest note
    // looked at on the falling edge, clear of the launching edge
    always @(negedge sys_clk) begin
        if (core_tx_valid === 1'b1 && tx_q.size() > 0) begin
            check(16'({core_tx.en, core_tx.data[3:0]}), tx_q.pop_front());
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        // straps: all low, all high, random; isolate gates drivers
        for (int i = 0; i < 3; i++) begin
            r = $random(seed);
            r[7:0] = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : r[7:0];
            do_reset(pms_pkg::PMS_MII, r[7:0]);
            check(16'(strap_done), 16'h1);
            check(16'(strap[7:5]), 16'(exp_strap(pull) >> 5));
            check(16'(strap[4:0]), 16'(exp_strap(pull) & 8'h1f));
            check(16'(rxd_oe), pull[5] ? 16'h0 : 16'hf);
            pull = ~pull;
            repeat (6) @(negedge sys_clk);
            check(16'(strap), 16'(exp_strap(~pull)));
        end
        // interrupt polarity, enable, pending and clear
        do_reset(pms_pkg::PMS_MII, 8'h00);
        for (int i = 0; i < 2; i++) begin
            irq_active_high = i[0];
            irq_enable = 8'h01;
            repeat (3) @(negedge sys_clk);
            check(16'(interrupt_pin), 16'(!i[0]));
            irq_event = 8'h81;
            @(negedge sys_clk);
            irq_event = 8'h00;
            @(negedge sys_clk);
            check(16'(interrupt_pin), 16'(i[0]));
            check(16'(irq_pending), 16'h81);
            irq_clear = 8'h01;
            @(negedge sys_clk);
            irq_clear = 8'h00;
            @(negedge sys_clk);
            check(16'(interrupt_pin), 16'(!i[0]));
            check(16'(irq_pending), 16'h80);
            // event and clear together: the event must survive
            irq_event = 8'h01;
            irq_clear = 8'h01;
            @(negedge sys_clk);
            irq_event = 8'h00;
            check(16'(irq_pending), 16'h81);
            irq_clear = 8'hff;
            @(negedge sys_clk);
            irq_clear = 8'h00;
        end
        // receive valid pin: plain in mii, merged with carrier in rmii
        for (int m = 0; m < 2; m++) begin
            do_reset(m ? pms_pkg::PMS_RMII : pms_pkg::PMS_MII, 8'h00);
            for (int j = 0; j < 4; j++) begin
                core_rx.dv = j[0];
                core_rx.crs = j[1];
                repeat (2) @(negedge sys_clk);
                check(16'(dv_o), 16'(j[0] | (j[1] & m[0])));
            end
        end
        // transmit: own clock in mii and rmii, partner clock back-to-back
        for (int m = 0; m < 3; m++) begin
            do_reset((m == 0) ? pms_pkg::PMS_MII :
                     (m == 1) ? pms_pkg::PMS_B2B : pms_pkg::PMS_RMII, 8'h00);
            check(16'(txc_oe), 16'(m == 0));
            r = $random(seed);
            mac_word = r[3:0];
            mac_go = 1'b1;
            repeat (24) @(negedge sys_clk);
            // note {enable, data}; rmii carries only two data bits
            tx_q.push_back((m == 2) ? 16'({1'b1, 2'h0, r[1:0]})
                                    : 16'({1'b1, r[3:0]}));
            drain(60);
            // clock pin driven with one high in four only in mii
            cnt = 0;
            repeat (8) begin
                @(negedge sys_clk);
                cnt += int'(txc_oe & txc_o);
            end
            check(16'(cnt), (m == 0) ? 16'h2 : 16'h0);
        end
        // smii receive stream: carrier, valid, data lsb first on bit 0
        do_reset(pms_pkg::PMS_SMII, 8'h00);
        r = $random(seed);
        core_rx = '0;
        core_rx.data = r[7:0];
        core_rx.dv = 1'b1;
        core_rx.crs = 1'b1;
        mac_go = 1'b1;
        repeat (12) @(negedge sys_clk);
        for (int k = 0; k < 30; k++) begin
            @(negedge sys_clk);
            sh = {sh[28:0], rxd_o[0]};
        end
        pat[9:8] = 2'h3;
        for (int k = 0; k < 8; k++) pat[7 - k] = r[k];
        found = 1'b0;
        for (int k = 0; k <= 20; k++) found |= (sh[k +: 10] === pat);
        check(16'(found), 16'h1);
        wrap_up();
    end
endmodule : pms_pin_mux_tb
`default_nettype wire
